// ### tcsr_pkg.sv
// Shared constants and types for the tick counter and status registers
package tcsr_pkg;
  // Register offsets
  localparam logic [7:0] OFF_TICK_COUNT = 8'h00;
  localparam logic [7:0] OFF_SUMMARY = 8'h01;
  localparam logic [7:0] OFF_SUPPLY = 8'h02;
  // Summary status bit positions
  localparam int SUM_DSP_BIT = 7;
  localparam int SUM_LINK_BIT = 5;
  localparam int SUM_MEMTEMP_BIT = 4;
  localparam int SUM_SUPPLY_BIT = 3;
  localparam int SUM_TEST_BIT = 2;
  localparam int SUM_RESET_BIT = 1;
  localparam int SUM_INIT_BIT = 0;
  // Supply fault bit positions
  localparam int SUP_UV_BIT = 7;
  localparam int SUP_AREG_BIT = 3;
  localparam int SUP_DREG_BIT = 2;
  localparam int SUP_MREG_BIT = 1;
  localparam int SUP_CONT_BIT = 0;
  // Reset values
  localparam logic [7:0] TICK_COUNT_RESET = 8'h00;
  localparam logic [9:0] PRESCALE_RESET = 10'h000;
  localparam logic RESET_FLAG_RESET = 1'b1;
  localparam logic INIT_FLAG_RESET = 1'b1;
  localparam logic TEST_FLAG_RESET = 1'b0;
  localparam logic LINK_FLAG_RESET = 1'b0;
  localparam logic [4:0] SUP_FLAGS_RESET = 5'h00;
  // Timing
  localparam int PRESCALE_DIV = 1000;
  localparam int CLK_MHZ = 40;
  localparam int SUP_RCV_US = 1000;
  localparam int SUP_RCV_CYCLES = SUP_RCV_US * CLK_MHZ;

  // Raw supply monitor levels
  typedef struct packed {
    logic uv;
    logic areg;
    logic dreg;
    logic mreg;
    logic cont;
  } tcsr_sup_mon_t;

  // Signal chain and memory/temperature fault levels
  typedef struct packed {
    logic selftest_incomplete;
    logic common_mode_fault;
    logic selftest_fault;
    logic factory_mem_fault;
    logic user_mem_fault;
    logic user_reg_check_fault;
    logic mem_write_active;
    logic temperature_range_fault;
  } tcsr_fault_in_t;
endpackage : tcsr_pkg

// ### tcsr_prescaler.sv
// Divide-by-N prescaler producing one enable pulse per period
`timescale 1ns/10ps
`default_nettype none
module tcsr_prescaler #(
  parameter int DIV = tcsr_pkg::PRESCALE_DIV,
  parameter int WIDTH = 10
) (
  input wire logic i_core_clk,
  input wire logic i_resetn,
  output logic o_tick
);
  logic [WIDTH-1:0] phase;
  logic [WIDTH-1:0] next_phase;
  wire at_terminal = (phase == WIDTH'(DIV - 1));

  // Wrap at the terminal count
  assign next_phase = at_terminal ? '0 : phase + 1'b1;

  // Phase and pulse start from zero so the first tick is a full period out
  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      phase <= tcsr_pkg::PRESCALE_RESET;
      o_tick <= 1'b0;
    end else begin
      phase <= next_phase;
      o_tick <= at_terminal;
    end
  end

  a_tick_single: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    o_tick |=> !o_tick ##1 !o_tick) else $error("prescaler tick not isolated");
  a_tick_phase: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    o_tick |-> phase == '0) else $error("tick out of phase with prescaler");
endmodule : tcsr_prescaler
`default_nettype wire

// ### tcsr_regs.sv
// Tick counter, summary status and supply fault status registers
`timescale 1ns/10ps
`default_nettype none
module tcsr_regs #(
  parameter int SUP_RCV_CYCLES = tcsr_pkg::SUP_RCV_CYCLES
) (
  input wire logic i_core_clk,
  input wire logic i_resetn,
  input wire logic i_rd_en,
  input wire logic [7:0] i_rd_addr,
  input wire logic i_wr_en,
  input wire logic [7:0] i_wr_addr,
  input wire logic [7:0] i_wr_data,
  input wire logic i_status_frame_sent,
  input wire logic i_link_status_read,
  input wire logic i_link_mismatch,
  input wire logic i_test_enter,
  input wire logic i_test_exit,
  input wire logic i_data_valid,
  input wire logic i_supply_report_disable,
  input wire tcsr_pkg::tcsr_sup_mon_t i_sup_mon,
  input wire tcsr_pkg::tcsr_fault_in_t i_fault_in,
  output logic [7:0] o_rd_data,
  output logic o_rd_valid
);
  localparam int TW = $clog2(SUP_RCV_CYCLES + 1);
  localparam logic [TW-1:0] RCV_LOAD = TW'(SUP_RCV_CYCLES);

  // Decode of a read address to the register contents
  function automatic logic [7:0] read_mux(input logic [7:0] addr, input logic [7:0] cnt,
                                          input logic [7:0] sum, input logic [7:0] sup);
    case (addr)
      tcsr_pkg::OFF_TICK_COUNT: read_mux = cnt;
      tcsr_pkg::OFF_SUMMARY: read_mux = sum;
      tcsr_pkg::OFF_SUPPLY: read_mux = sup;
      default: read_mux = 8'h00;
    endcase
  endfunction : read_mux

  logic tick;
  logic [7:0] tick_count;
  logic reset_occurred;
  logic init_pending;
  logic factory_test_active;
  logic link_fault;
  tcsr_pkg::tcsr_sup_mon_t sup_flags;
  logic [TW-1:0] rcv_timer;

  // Prescaler for the tick counter
  tcsr_prescaler #(
    .DIV(tcsr_pkg::PRESCALE_DIV),
    .WIDTH(10)
  ) u_prescaler (
    .i_core_clk(i_core_clk),
    .i_resetn(i_resetn),
    .o_tick(tick)
  );

  // Grouped fault summaries
  wire dsp_fault = i_fault_in.selftest_incomplete | i_fault_in.common_mode_fault
                 | i_fault_in.selftest_fault;
  wire memory_temp_fault_summary = i_fault_in.factory_mem_fault | i_fault_in.user_mem_fault
                                 | i_fault_in.user_reg_check_fault | i_fault_in.mem_write_active
                                 | i_fault_in.temperature_range_fault;
  wire supply_fault_summary = |sup_flags;
  wire sup_raw_any = |i_sup_mon;

  // Register images; reserved bits tie to zero
  wire [7:0] summary_status = {dsp_fault, 1'b0, link_fault, memory_temp_fault_summary,
                               supply_fault_summary, factory_test_active, reset_occurred,
                               init_pending};
  wire [7:0] supply_fault_status = {sup_flags.uv, 3'b000, sup_flags.areg, sup_flags.dreg,
                                    sup_flags.mreg, sup_flags.cont};

  // Read strobes that carry clear side effects
  wire summary_read = i_rd_en && (i_rd_addr == tcsr_pkg::OFF_SUMMARY);
  wire [7:0] next_rd_data = read_mux(i_rd_addr, tick_count, summary_status,
                                     supply_fault_status);

  // Writes are accepted on the port but change nothing
  wire write_ignored = i_wr_en & (|i_wr_addr | |i_wr_data) & 1'b0;

  // Recovery timer: reload while any monitor reports, then run down
  wire [TW-1:0] next_rcv_timer = sup_raw_any ? RCV_LOAD
                               : (rcv_timer != '0) ? rcv_timer - 1'b1 : rcv_timer;
  wire rcv_expired = !sup_raw_any && (rcv_timer == '0);
  // Disable clears flags as soon as monitors go quiet; otherwise hold through recovery
  wire sup_clear = i_supply_report_disable ? !sup_raw_any : rcv_expired;
  wire tcsr_pkg::tcsr_sup_mon_t next_sup_flags = sup_clear ? i_sup_mon
                                               : (sup_flags | i_sup_mon);

  // Tick counter wraps naturally at eight bits
  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      tick_count <= tcsr_pkg::TICK_COUNT_RESET;
    end else if (tick) begin
      tick_count <= tick_count + 8'h01;
    end
  end

  // Summary flags; an event in the clear cycle wins over the clear
  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      reset_occurred <= tcsr_pkg::RESET_FLAG_RESET;
      init_pending <= tcsr_pkg::INIT_FLAG_RESET;
      factory_test_active <= tcsr_pkg::TEST_FLAG_RESET;
      link_fault <= tcsr_pkg::LINK_FLAG_RESET;
    end else begin
      if (summary_read || i_status_frame_sent) begin
        reset_occurred <= 1'b0;
      end
      if (i_data_valid) begin
        init_pending <= 1'b0;
      end
      if (i_test_enter) begin
        factory_test_active <= 1'b1;
      end else if (i_test_exit) begin
        factory_test_active <= 1'b0;
      end
      if (i_link_mismatch) begin
        link_fault <= 1'b1;
      end else if (i_link_status_read || i_status_frame_sent) begin
        link_fault <= 1'b0;
      end
    end
  end

  // Supply flags and shared recovery timer
  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      sup_flags <= tcsr_pkg::SUP_FLAGS_RESET;
      rcv_timer <= '0;
    end else begin
      sup_flags <= next_sup_flags;
      rcv_timer <= next_rcv_timer;
    end
  end

  // Read answer one cycle after the strobe; unmapped reads return zero
  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      o_rd_data <= 8'h00;
      o_rd_valid <= 1'b0;
    end else begin
      o_rd_data <= i_rd_en ? next_rd_data : 8'h00;
      o_rd_valid <= i_rd_en & ~write_ignored;
    end
  end

  // Counter stepping
  sequence s_tick_seen;
    tick ##1 1'b1;
  endsequence
  a_count_step: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    tick |=> tick_count == $past(tick_count) + 8'h01) else $error("count did not step by one");
  a_count_hold: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    !tick |=> $stable(tick_count)) else $error("count moved without tick");
  a_count_wrap: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    (tick && tick_count == 8'hff) |=> tick_count == 8'h00) else $error("count did not wrap");
  a_reset_clears: assert property (@(posedge i_core_clk)
    !i_resetn |=> tick_count == 8'h00 && reset_occurred && init_pending) else $error("reset values wrong");

  // Summary read path
  a_dsp_read: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    summary_read |=> o_rd_valid && o_rd_data[tcsr_pkg::SUM_DSP_BIT] == $past(dsp_fault)
                     && !o_rd_data[6]) else $error("summary bit 7 wrong");
  a_reset_flag_clear: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    summary_read |=> !reset_occurred ##1 !reset_occurred) else $error("reset flag not cleared");
  a_init_clear: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    i_data_valid |=> !init_pending) else $error("init flag not cleared");
  a_test_track: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    i_test_enter |=> factory_test_active) else $error("test mode not flagged");
  a_link_set: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    i_link_mismatch |=> summary_status[tcsr_pkg::SUM_LINK_BIT]) else $error("link flag not set");
  a_unmapped_zero: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    (i_rd_en && i_rd_addr > tcsr_pkg::OFF_SUPPLY) |=> o_rd_data == 8'h00) else $error("unmapped read nonzero");

  // Supply flags and recovery
  a_uv_set: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    i_sup_mon.uv |=> supply_fault_status[tcsr_pkg::SUP_UV_BIT]
                     && summary_status[tcsr_pkg::SUM_SUPPLY_BIT]) else $error("undervoltage not flagged");
  a_timer_reload: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    sup_raw_any |=> rcv_timer == RCV_LOAD) else $error("recovery timer not reloaded");
  a_sup_hold: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    (sup_flags.cont && !i_supply_report_disable && rcv_timer > TW'(1)) |=> sup_flags.cont)
    else $error("supply flag cleared before recovery");
  a_tick_step_seq: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    s_tick_seen |-> tick_count != $past(tick_count)) else $error("tick lost");

  // Read port timing: one answer per strobe, quiet otherwise
  sequence s_summary_taken;
    summary_read ##1 o_rd_valid;
  endsequence
  a_rd_valid_pulse: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    i_rd_en |=> o_rd_valid)
    else $error("read strobe not answered");
  a_rd_idle: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    !i_rd_en |=> !o_rd_valid && o_rd_data == 8'h00)
    else $error("read port not idle");
  a_count_read: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    (i_rd_en && i_rd_addr == tcsr_pkg::OFF_TICK_COUNT) |=> o_rd_data == $past(tick_count))
    else $error("count read wrong");
  a_supply_read: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    (i_rd_en && i_rd_addr == tcsr_pkg::OFF_SUPPLY) |=> o_rd_data == $past(supply_fault_status))
    else $error("supply read wrong");
  a_sup_reserved: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    (i_rd_en && i_rd_addr == tcsr_pkg::OFF_SUPPLY) |=> o_rd_data[6:4] == 3'b000)
    else $error("supply reserved bits nonzero");

  // Summary bits as read back; the flags are sampled at the taking edge
  a_memtemp_read: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    s_summary_taken |-> o_rd_data[tcsr_pkg::SUM_MEMTEMP_BIT] == $past(memory_temp_fault_summary))
    else $error("summary bit 4 wrong");
  a_link_read: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    s_summary_taken |-> o_rd_data[tcsr_pkg::SUM_LINK_BIT] == $past(link_fault))
    else $error("summary bit 5 wrong");
  a_supply_sum_read: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    s_summary_taken |-> o_rd_data[tcsr_pkg::SUM_SUPPLY_BIT] == $past(|sup_flags))
    else $error("summary bit 3 wrong");
  a_test_read: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    s_summary_taken |-> o_rd_data[tcsr_pkg::SUM_TEST_BIT] == $past(factory_test_active))
    else $error("summary bit 2 wrong");
  a_reset_read: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    s_summary_taken |-> o_rd_data[tcsr_pkg::SUM_RESET_BIT] == $past(reset_occurred))
    else $error("summary bit 1 wrong");
  a_init_read: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    s_summary_taken |-> o_rd_data[tcsr_pkg::SUM_INIT_BIT] == $past(init_pending))
    else $error("summary bit 0 wrong");

  // Flag lifetimes; only reset can raise the reset and init flags
  a_frame_clear: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    i_status_frame_sent |=> !reset_occurred)
    else $error("frame did not clear reset flag");
  a_reset_no_set: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    !reset_occurred |=> !reset_occurred)
    else $error("reset flag rose without reset");
  a_init_no_set: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    !init_pending |=> !init_pending)
    else $error("init flag rose without reset");
  a_test_exit: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    (i_test_exit && !i_test_enter) |=> !factory_test_active)
    else $error("test flag not cleared");
  a_test_hold: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    (!i_test_enter && !i_test_exit) |=> $stable(factory_test_active))
    else $error("test flag moved by itself");
  a_link_clear: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    (!i_link_mismatch && i_link_status_read) |=> !link_fault)
    else $error("link flag not cleared");

  // Each regulator and continuity monitor sets its own bit
  a_areg_set: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    i_sup_mon.areg |=> supply_fault_status[tcsr_pkg::SUP_AREG_BIT])
    else $error("analog regulator not flagged");
  a_dreg_set: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    i_sup_mon.dreg |=> supply_fault_status[tcsr_pkg::SUP_DREG_BIT])
    else $error("digital regulator not flagged");
  a_mreg_set: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    i_sup_mon.mreg |=> supply_fault_status[tcsr_pkg::SUP_MREG_BIT])
    else $error("memory regulator not flagged");
  a_cont_set: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    i_sup_mon.cont |=> supply_fault_status[tcsr_pkg::SUP_CONT_BIT])
    else $error("continuity not flagged");

  // Recovery countdown and the two clearing styles
  a_timer_run: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    (!sup_raw_any && rcv_timer != '0) |=> rcv_timer == $past(rcv_timer) - 1'b1)
    else $error("recovery timer not counting");
  a_dis_clear: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    (i_supply_report_disable && !sup_raw_any) |=> sup_flags == '0)
    else $error("flags held with reporting disabled");
  a_expired_clear: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    (!i_supply_report_disable && rcv_expired) |=> sup_flags == '0)
    else $error("flags held after recovery");
  a_write_no_count: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    (i_wr_en && !tick) |=> $stable(tick_count))
    else $error("write changed the count");
endmodule : tcsr_regs
`default_nettype wire

// ### tcsr_host.sv
// Host model that reads the registers over the one-cycle read port
`timescale 1ns/10ps
`default_nettype none
module tcsr_host (
  input wire logic i_core_clk,
  input wire logic [7:0] i_rd_data,
  input wire logic i_rd_valid,
  output logic o_rd_en,
  output logic [7:0] o_rd_addr
);
  initial begin
    o_rd_en = 1'b0;
    o_rd_addr = 8'h00;
  end
  // Request held up to the taking edge, answer taken 2 ns after that same edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge i_core_clk);
    #2;
    o_rd_en = 1'b1;
    o_rd_addr = a;
    @(posedge i_core_clk);
    #2;
    o_rd_en = 1'b0;
    o_rd_addr = ~a; // Released address must not look valid
    d = (i_rd_valid === 1'b1) ? i_rd_data : 8'hxx;
  endtask : rd
endmodule : tcsr_host
`default_nettype wire

// ### tb_tick_counter_and_status_regs.sv
// Self-checking testbench for the tick counter and status registers
`timescale 1ns/10ps
`default_nettype none
module tb_tick_counter_and_status_regs;
  localparam int N = 8;
  logic clk = 1'b0, rstn = 1'b0, wr_en = 1'b0, dis = 1'b0, rd_en, rd_valid;
  logic [7:0] wr_addr = 8'h00, wr_data = 8'h00, rd_addr, rd_data, d;
  logic [5:0] ev = 6'h00;
  tcsr_pkg::tcsr_sup_mon_t mon = 5'h00;
  tcsr_pkg::tcsr_fault_in_t fin = 8'h00;
  int fail_count = 0, compares = 0, ecnt = 0, cyc = 0, e0;
  int m_rst, m_init, m_test, m_link, m_sup;
  logic [31:0] lf = 32'h50cc2971;
  initial begin
    forever #12.5 clk = ~clk;
  end
  // Edge count since reset release feeds the tick model; cycle ceiling cuts hangs
  always @(posedge clk) begin
    ecnt <= rstn ? ecnt + 1 : 0;
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      close_out();
    end
  end
  tcsr_regs #(.SUP_RCV_CYCLES(N)) DUT (.i_core_clk(clk), .i_resetn(rstn), .i_rd_en(rd_en),
    .i_rd_addr(rd_addr), .i_wr_en(wr_en), .i_wr_addr(wr_addr), .i_wr_data(wr_data),
    .i_status_frame_sent(ev[0]), .i_link_status_read(ev[1]), .i_link_mismatch(ev[2]),
    .i_test_enter(ev[3]), .i_test_exit(ev[4]), .i_data_valid(ev[5]),
    .i_supply_report_disable(dis), .i_sup_mon(mon), .i_fault_in(fin),
    .o_rd_data(rd_data), .o_rd_valid(rd_valid));
  tcsr_host HOST (.i_core_clk(clk), .i_rd_data(rd_data), .i_rd_valid(rd_valid),
    .o_rd_en(rd_en), .o_rd_addr(rd_addr));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  // Expected register value, valid when called just after an edge
  function automatic logic [7:0] model(input logic [7:0] a);
    case (a)
      tcsr_pkg::OFF_TICK_COUNT: return 8'(ecnt / 1000);
      tcsr_pkg::OFF_SUMMARY: return {|fin[7:5], 1'b0, m_link[0], |fin[4:0], |m_sup[4:0], m_test[0],
        m_rst[0], m_init[0]};
      tcsr_pkg::OFF_SUPPLY: return {m_sup[4], 3'h0, m_sup[3:0]};
      default: return 8'h00;
    endcase
  endfunction : model
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic rdc(input logic [7:0] a);
    logic [7:0] e;
    e = model(a);
    HOST.rd(a, d);
    chk($sformatf("reg %h", a), e, d);
    if (a == tcsr_pkg::OFF_SUMMARY) m_rst = 0;
  endtask : rdc
  // One-cycle event pulse
  task automatic pulse(input int k);
    @(posedge clk);
    #2;
    ev[k] = 1'b1;
    @(posedge clk);
    #2;
    ev[k] = 1'b0;
  endtask : pulse
  // No reads while reset is held, so supply flags are never judged then
  task automatic rst();
    @(posedge clk);
    #2;
    rstn = 1'b0;
    repeat (4) @(posedge clk);
    #2;
    rstn = 1'b1;
    m_rst = 1;
    m_init = 1;
    m_test = 0;
    m_link = 0;
    m_sup = 0;
  endtask : rst
  task automatic close_out();
    $display("fail_count %0d compares %0d", fail_count, compares);
    if (fail_count == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : close_out
  initial begin
    rst();
    rdc(tcsr_pkg::OFF_SUMMARY);
    rdc(tcsr_pkg::OFF_SUMMARY);
    rdc(tcsr_pkg::OFF_TICK_COUNT);
    rdc(8'h05);
    // Random writes to offsets 0 to 3 leave contents alone
    for (int i = 0; i < 4; i++) begin
      lf = lfsr(lf);
      @(posedge clk);
      #2;
      wr_en = 1'b1;
      wr_addr = i[7:0];
      wr_data = lf[7:0];
      @(posedge clk);
      #2;
      wr_en = 1'b0;
      rdc(i[7:0]);
    end
    for (int i = 0; i < 8; i++) begin
      lf = lfsr(lf);
      fin = lf[15:8];
      rdc(tcsr_pkg::OFF_SUMMARY);
    end
    fin = 8'h00;
    pulse(2); m_link = 1; rdc(tcsr_pkg::OFF_SUMMARY);
    pulse(0); m_link = 0; rdc(tcsr_pkg::OFF_SUMMARY);
    pulse(2); pulse(1); rdc(tcsr_pkg::OFF_SUMMARY);
    pulse(3); m_test = 1; pulse(0); rdc(tcsr_pkg::OFF_SUMMARY);
    pulse(4); m_test = 0; rdc(tcsr_pkg::OFF_SUMMARY);
    pulse(5); m_init = 0; rdc(tcsr_pkg::OFF_SUMMARY);
    // Each monitor alone; flag must stand to the last edge of the hold
    for (int k = 0; k < 5; k++) begin
      @(posedge clk);
      #2;
      mon = 5'(1 << k);
      @(posedge clk);
      #2;
      mon = 5'h00;
      e0 = ecnt;
      m_sup = 1 << k;
      rdc(tcsr_pkg::OFF_SUPPLY);
      rdc(tcsr_pkg::OFF_SUMMARY);
      while (ecnt < e0 + N - 1) begin
        @(posedge clk);
        #2;
      end
      rdc(tcsr_pkg::OFF_SUPPLY);
      m_sup = 0;
      rdc(tcsr_pkg::OFF_SUPPLY);
    end
    // Without hold the flags just follow the monitors
    dis = 1'b1;
    mon = 5'h1f;
    m_sup = 31;
    rdc(tcsr_pkg::OFF_SUPPLY);
    mon = 5'h00;
    m_sup = 0;
    rdc(tcsr_pkg::OFF_SUPPLY);
    dis = 1'b0;
    // Tick count on both sides of the first two prescaler periods
    for (int t = 999; t < 2000; t += 1000) begin
      while (ecnt < t) begin
        @(posedge clk);
        #2;
      end
      rdc(tcsr_pkg::OFF_TICK_COUNT);
      rdc(tcsr_pkg::OFF_TICK_COUNT);
    end
    pulse(3);
    rst();
    rdc(tcsr_pkg::OFF_SUMMARY);
    rdc(tcsr_pkg::OFF_TICK_COUNT);
    close_out();
  end
endmodule : tb_tick_counter_and_status_regs
`default_nettype wire
